// file: design/cssp_pkg.sv
// Package holding the register map, field positions, timing and types of the serial shift port.
package cssp_pkg;
    localparam logic [5:0] ADR_PORT_PIN_MODE_A = 6'h04;
    localparam logic [5:0] ADR_SERIAL_MODE_A = 6'h05;
    localparam logic [5:0] ADR_SERIAL_DATA_LOW = 6'h06;
    localparam logic [5:0] ADR_SERIAL_DATA_HIGH = 6'h07;
    localparam logic [5:0] ADR_MISC_CONTROL = 6'h0C;
    localparam logic [5:0] ADR_SERIAL_MODE_B = 6'h28;
    localparam logic [5:0] ADR_IRQ_STATUS = 6'h30;
    localparam logic [5:0] ADR_IRQ_CLEAR = 6'h31;
    localparam logic [5:0] ADR_IRQ_ENABLE = 6'h32;
    localparam logic [5:0] ADR_START = 6'h33;
    localparam logic [5:0] ADR_COUNTER = 6'h34;

    localparam int SMB_POSTDIV_BIT = 0;
    localparam int SMB_IDLE_LVL_BIT = 1;
    localparam int PORT_PIN_MODE_A_SO_BIT = 0;
    localparam int PORT_PIN_MODE_A_SI_BIT = 1;

    localparam logic [3:0] REG_RESET = 4'h0;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic SO_RESET = 1'b1;
    localparam logic [2:0] SRC_SYSCLK = 3'h6;
    localparam logic [2:0] SRC_EXT = 3'h7;
    localparam logic [2:0] CNT_LAST = 3'h7;
    localparam logic [2:0] CNT_ZERO = 3'h0;
    localparam logic [1:0] MODE_CONT = 2'h0;

    localparam int CLK_PERIOD_NS = 40;
    localparam int INSTR_CYCLE_NS = 40;
    localparam int CYC_PER_INSTR = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TAP_MAX_DEF = 2048;

    typedef struct packed {
        logic pin_en;
        logic [2:0] src;
    } cssp_mode_a_t;

    typedef enum logic [1:0] {
        ST_STS_WAIT,
        ST_CLK_WAIT,
        ST_XFER,
        ST_CONT
    } cssp_state_t;
endpackage

// file: design/cssp_top.sv
// Clocked serial shift port with its register file, shift clock generator and interrupt.
// Function
// - Eight bits per transfer, one per clock.
// - Mode A write initializes the port.
// - Pin-mode bits select clock, tx, rx, both.
// - Mode A sets clock pin; pin mode sets data.
// - Clock from pin, prescaler or system clock.
// - Data register loaded, read, shifted by clock.
// - Output level set by shift or idle control.
// - Start instruction starts transfer, clears counter.
// - Counter advances on each rising clock edge, except under the continuous clock.
// - Eighth clock or abort: clear, flag, stop; pin clock's eighth and a start-instruction abort rearm for the next fall.
// - Prescaler clock period four to 8192 cycles.
// - Mode A low bits pick prescaler tap.
// - Mode B bit zero: divide by two or four.
// - Mode A write acts two cycles later.
// - Mode A write stops clock, flags running transfer.
// - Internal clock stops after eight pulses, except in pin mode zero.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cssp_top #(
    parameter int MAX_TAP = cssp_pkg::TAP_MAX_DEF
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic [5:0] ADDR_I,
    input wire logic [3:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [3:0] RDATA_O,
    output logic IRQ_O,
    input wire logic SHIFT_CLOCK_PIN_I,
    output logic SHIFT_CLOCK_PIN_O,
    output logic SHIFT_CLOCK_PIN_OE_O,
    input wire logic SERIAL_IN_PIN_I,
    output logic SERIAL_OUT_PIN_O,
    output logic SERIAL_OUT_PIN_OE_O
);
    logic rst_s1_q, rst_n;
    logic [2:0] sck_sync_q;
    logic [1:0] si_sync_q;
    cssp_pkg::cssp_mode_a_t sma_q, sma_eff_q;
    logic [3:0] port_pin_mode_a_q, smb_q, misc_q;
    logic [7:0] data_q;
    logic [2:0] cnt_q;
    cssp_pkg::cssp_state_t state_q;
    logic sck_q, so_q, stat_q, en_q;
    logic [15:0] half_q;
    logic wr_sma, wr_sts, wr_dl, wr_dh, wr_smb, wr_clr;
    logic int_src, clk_run, tog, clk_fall, clk_rise, mode_cont, done, abort_flag;

    // The prescaler tap shrinks with MAX_TAP so that a simulation can run short periods.
    function automatic logic [15:0] half_len(input cssp_pkg::cssp_mode_a_t m, input logic post4);
        logic [15:0] t;
        t = 16'(MAX_TAP >> {m.src, 1'b0});
        if (post4) begin
            t = {t[14:0], 1'b0};
        end
        t = 16'(t * cssp_pkg::CYC_PER_INSTR);
        if (m.src == cssp_pkg::SRC_SYSCLK) begin
            t = 16'h0001;
        end
        return t;
    endfunction

    function automatic logic addr_is(input logic [5:0] a, input logic [5:0] b);
        return a == b;
    endfunction

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // Pins are asynchronous to the system clock, so both pass two flops before use.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            sck_sync_q <= 3'h7;
            si_sync_q <= 2'h0;
        end else if (CE_I) begin
            sck_sync_q <= {sck_sync_q[1:0], SHIFT_CLOCK_PIN_I};
            si_sync_q <= {si_sync_q[0], SERIAL_IN_PIN_I};
        end
    end

    assign wr_sma = CE_I && WR_I && addr_is(ADDR_I, cssp_pkg::ADR_SERIAL_MODE_A);
    assign wr_sts = CE_I && WR_I && addr_is(ADDR_I, cssp_pkg::ADR_START);
    assign wr_dl = CE_I && WR_I && addr_is(ADDR_I, cssp_pkg::ADR_SERIAL_DATA_LOW);
    assign wr_dh = CE_I && WR_I && addr_is(ADDR_I, cssp_pkg::ADR_SERIAL_DATA_HIGH);
    assign wr_smb = CE_I && WR_I && addr_is(ADDR_I, cssp_pkg::ADR_SERIAL_MODE_B);
    assign wr_clr = CE_I && WR_I && addr_is(ADDR_I, cssp_pkg::ADR_IRQ_CLEAR);

    assign int_src = sma_eff_q.src != cssp_pkg::SRC_EXT;
    assign mode_cont = port_pin_mode_a_q[1:0] == cssp_pkg::MODE_CONT;
    assign clk_run = sma_eff_q.pin_en && int_src && (state_q != cssp_pkg::ST_STS_WAIT);
    assign tog = CE_I && clk_run && (half_q == 16'h0000);
    // The external clock is filtered only by the synchroniser; a noise pulse counts as a clock.
    always_comb begin
        if (int_src) begin
            clk_fall = tog && sck_q;
            clk_rise = tog && !sck_q;
        end else begin
            clk_fall = CE_I && sma_eff_q.pin_en && sck_sync_q[2] && !sck_sync_q[1];
            clk_rise = CE_I && sma_eff_q.pin_en && !sck_sync_q[2] && sck_sync_q[1];
        end
    end
    assign done = clk_rise && (state_q == cssp_pkg::ST_XFER) && (cnt_q == cssp_pkg::CNT_LAST);
    // No flag when a transfer is cut during the first low pulse, as the counter is still zero.
    assign abort_flag = (wr_sma || wr_sts) && (state_q == cssp_pkg::ST_XFER) && (cnt_q != cssp_pkg::CNT_ZERO);

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            port_pin_mode_a_q <= cssp_pkg::REG_RESET;
            sma_q <= cssp_pkg::REG_RESET;
            sma_eff_q <= cssp_pkg::REG_RESET;
            smb_q <= cssp_pkg::REG_RESET;
            misc_q <= cssp_pkg::REG_RESET;
            en_q <= 1'b0;
        end else if (CE_I) begin
            sma_eff_q <= sma_q;
            if (wr_sma) begin
                sma_q <= WDATA_I;
            end
            if (WR_I && addr_is(ADDR_I, cssp_pkg::ADR_PORT_PIN_MODE_A)) begin
                port_pin_mode_a_q <= WDATA_I;
            end
            if (wr_smb) begin
                smb_q <= WDATA_I;
            end
            if (WR_I && addr_is(ADDR_I, cssp_pkg::ADR_MISC_CONTROL)) begin
                misc_q <= WDATA_I;
            end
            if (WR_I && addr_is(ADDR_I, cssp_pkg::ADR_IRQ_ENABLE)) begin
                en_q <= WDATA_I[0];
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= cssp_pkg::ST_STS_WAIT;
        end else if (CE_I) begin
            if (wr_sma) begin
                state_q <= cssp_pkg::ST_STS_WAIT;
            end else begin
                unique case (state_q)
                    cssp_pkg::ST_STS_WAIT: begin
                        if (wr_sts) begin
                            state_q <= cssp_pkg::ST_CLK_WAIT;
                        end
                    end
                    cssp_pkg::ST_CLK_WAIT: begin
                        if (!wr_sts && clk_fall) begin
                            state_q <= (mode_cont && int_src) ? cssp_pkg::ST_CONT : cssp_pkg::ST_XFER;
                        end
                    end
                    cssp_pkg::ST_XFER: begin
                        if (wr_sts) begin
                            state_q <= cssp_pkg::ST_CLK_WAIT;
                        end else if (done) begin
                            state_q <= int_src ? cssp_pkg::ST_STS_WAIT : cssp_pkg::ST_CLK_WAIT;
                        end
                    end
                    cssp_pkg::ST_CONT: begin
                        state_q <= cssp_pkg::ST_CONT;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= cssp_pkg::CNT_ZERO;
        end else if (CE_I) begin
            if (wr_sma || wr_sts) begin
                cnt_q <= cssp_pkg::CNT_ZERO;
            end else if (clk_rise && (state_q == cssp_pkg::ST_XFER)) begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end

    // Set wins over a clear in the same cycle so that no completion is lost.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= 1'b0;
        end else if (CE_I) begin
            if (done || abort_flag) begin
                stat_q <= 1'b1;
            end else if (wr_clr && WDATA_I[0]) begin
                stat_q <= 1'b0;
            end
        end
    end
    assign IRQ_O = stat_q && en_q;

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            half_q <= 16'h0000;
            sck_q <= 1'b1;
        end else if (CE_I) begin
            if (!clk_run) begin
                half_q <= 16'(half_len(sma_eff_q, smb_q[cssp_pkg::SMB_POSTDIV_BIT]) - 16'h0001);
                sck_q <= 1'b1;
            end else if (tog) begin
                half_q <= 16'(half_len(sma_eff_q, smb_q[cssp_pkg::SMB_POSTDIV_BIT]) - 16'h0001);
                sck_q <= !sck_q;
            end else begin
                half_q <= half_q - 16'h0001;
            end
        end
    end

    // Writes to the data digits are taken in any state except in a shift cycle, where the shift wins; software should only write while idle.
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= cssp_pkg::DATA_RESET;
        end else if (CE_I) begin
            if (clk_rise && (state_q == cssp_pkg::ST_XFER)) begin
                data_q <= {port_pin_mode_a_q[cssp_pkg::PORT_PIN_MODE_A_SI_BIT] && si_sync_q[1], data_q[7:1]};
            end else begin
                if (wr_dl) begin
                    data_q[3:0] <= WDATA_I;
                end
                if (wr_dh) begin
                    data_q[7:4] <= WDATA_I;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            so_q <= cssp_pkg::SO_RESET;
        end else if (CE_I) begin
            if (clk_fall && (state_q inside {cssp_pkg::ST_CLK_WAIT, cssp_pkg::ST_XFER})) begin
                so_q <= data_q[0];
            end else if (wr_smb && (state_q inside {cssp_pkg::ST_STS_WAIT, cssp_pkg::ST_CLK_WAIT})) begin
                so_q <= WDATA_I[cssp_pkg::SMB_IDLE_LVL_BIT];
            end
        end
    end

    assign SHIFT_CLOCK_PIN_O = sck_q;
    assign SHIFT_CLOCK_PIN_OE_O = sma_eff_q.pin_en && int_src;
    assign SERIAL_OUT_PIN_O = so_q;
    assign SERIAL_OUT_PIN_OE_O = port_pin_mode_a_q[cssp_pkg::PORT_PIN_MODE_A_SO_BIT];

    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            RDATA_O <= 4'h0;
        end else if (CE_I) begin
            RDATA_O <= 4'h0;
            if (RD_I) begin
                unique case (ADDR_I)
                    cssp_pkg::ADR_PORT_PIN_MODE_A: RDATA_O <= port_pin_mode_a_q;
                    cssp_pkg::ADR_SERIAL_DATA_LOW: RDATA_O <= data_q[3:0];
                    cssp_pkg::ADR_SERIAL_DATA_HIGH: RDATA_O <= data_q[7:4];
                    cssp_pkg::ADR_MISC_CONTROL: RDATA_O <= misc_q;
                    cssp_pkg::ADR_SERIAL_MODE_B: RDATA_O <= smb_q;
                    cssp_pkg::ADR_IRQ_STATUS: RDATA_O <= {3'h0, stat_q};
                    cssp_pkg::ADR_IRQ_ENABLE: RDATA_O <= {3'h0, en_q};
                    cssp_pkg::ADR_COUNTER: RDATA_O <= {state_q == cssp_pkg::ST_XFER, cnt_q};
                    default: RDATA_O <= 4'h0;
                endcase
            end
        end
    end

    // Helper that counts cycles between clock toggles for the period check.
    logic [15:0] gap_q;
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 16'h0000;
        end else if (CE_I) begin
            gap_q <= (!clk_run || tog) ? 16'h0000 : 16'(gap_q + 16'h0001);
        end
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!rst_n);

    sequence s_last_rise;
        done && !wr_sma && !wr_sts;
    endsequence
    sequence s_cleared_flagged;
        (cnt_q == cssp_pkg::CNT_ZERO) && stat_q;
    endsequence

    property p_start_clears;
        wr_sts && !wr_sma |=> cnt_q == cssp_pkg::CNT_ZERO && state_q != cssp_pkg::ST_STS_WAIT;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start did not clear counter");

    property p_count_step;
        clk_rise && state_q == cssp_pkg::ST_XFER && !wr_sma && !wr_sts |=> cnt_q == 3'($past(cnt_q) + 3'h1);
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not advance");

    property p_eighth_done;
        s_last_rise |=> s_cleared_flagged;
    endproperty
    a_eighth_done: assert property (p_eighth_done) else $error("eighth clock not completed");

    property p_mode_write_init;
        wr_sma |=> state_q == cssp_pkg::ST_STS_WAIT && cnt_q == cssp_pkg::CNT_ZERO;
    endproperty
    a_mode_write_init: assert property (p_mode_write_init) else $error("mode write did not initialize");

    property p_abort_flag;
        wr_sma && state_q == cssp_pkg::ST_XFER && cnt_q != cssp_pkg::CNT_ZERO |=> stat_q;
    endproperty
    a_abort_flag: assert property (p_abort_flag) else $error("abort did not set flag");

    property p_mode_delay;
        wr_sma && CE_I ##1 CE_I |=> sma_eff_q == $past(WDATA_I, 2);
    endproperty
    a_mode_delay: assert property (p_mode_delay) else $error("mode A not effective on second cycle");

    property p_clock_stops;
        (s_last_rise and int_src) |=> SHIFT_CLOCK_PIN_O [*4];
    endproperty
    a_clock_stops: assert property (p_clock_stops) else $error("internal clock ran past eight");

    property p_half_period;
        tog && $stable(smb_q) && $stable(sma_eff_q) |-> gap_q == 16'(half_len(sma_eff_q, smb_q[0]) - 16'h0001);
    endproperty
    a_half_period: assert property (p_half_period) else $error("shift clock period wrong");

    property p_drive_on_fall;
        clk_fall && state_q == cssp_pkg::ST_XFER && !wr_sma |=> SERIAL_OUT_PIN_O == $past(data_q[0]);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("output bit not driven on fall");

    property p_irq_follows;
        stat_q && en_q |-> IRQ_O ##1 (IRQ_O || !stat_q || !en_q);
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

    property p_flag_sticky;
        stat_q && !(wr_clr && WDATA_I[0]) |=> stat_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("status bit dropped without clear");

    property p_count_hold;
        state_q != cssp_pkg::ST_XFER && !wr_sts && !wr_sma |=> $stable(cnt_q);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counter moved outside a transfer");

    property p_idle_clock_high;
        state_q == cssp_pkg::ST_STS_WAIT && CE_I |=> SHIFT_CLOCK_PIN_O;
    endproperty
    a_idle_clock_high: assert property (p_idle_clock_high) else $error("shift clock not idle high");

    property p_idle_level;
        wr_smb && state_q == cssp_pkg::ST_STS_WAIT |=> SERIAL_OUT_PIN_O == $past(WDATA_I[cssp_pkg::SMB_IDLE_LVL_BIT]);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle output level not applied");

    property p_read_data_low;
        CE_I && RD_I && ADDR_I == cssp_pkg::ADR_SERIAL_DATA_LOW |=> RDATA_O == $past(data_q[3:0]);
    endproperty
    a_read_data_low: assert property (p_read_data_low) else $error("data low digit read wrong");
endmodule
`default_nettype wire

// file: verification/cssp_peer.sv
// Behavioural external serial device on the clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module cssp_peer (
    input wire logic sck,
    input wire logic so,
    input wire logic arm,
    input wire logic ext_go,
    input wire logic [7:0] tx,
    output logic si,
    output logic sck_drv,
    output var int n_rise,
    output var int period,
    output logic [7:0] rx
);
    time t_last;
    int idx;
    initial begin
        si = 1'b1;
        sck_drv = 1'b1;
        n_rise = 0;
        period = 0;
        rx = 8'h00;
        t_last = 0;
        idx = 0;
    end
    // Between frames the data line shows the inverse, so stale bits are never mistaken for data.
    always @(posedge arm) begin
        n_rise = 0;
        idx = 0;
        si = ~si;
    end
    always @(negedge sck) begin
        if (idx < 8) begin
            si = tx[idx];
            idx = idx + 1;
        end
    end
    always @(posedge sck) begin
        if (n_rise < 8) begin
            rx = {so, rx[7:1]};
        end
        period = int'($time - t_last);
        t_last = $time;
        n_rise = n_rise + 1;
        if (n_rise == 8) begin
            si <= #120 ~si;
        end
    end
    // Half periods are long enough to cover the port's input synchroniser.
    always @(posedge ext_go) begin
        repeat (8) begin
            #250 sck_drv = 1'b0;
            #250 sck_drv = 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: verification/cssp_top_tb.sv
// Self-checking testbench of the serial shift port.
`timescale 1ns/1ps
`default_nettype none
module cssp_top_tb;
    localparam int TAP = 32;
    logic clk, rst_b, ce, wr, rd, arm, ext_go, irq, sck_o, sck_oe, so, so_oe, si, sck_drv, sck;
    logic [5:0] addr;
    logic [3:0] wdata, rdata, lo, hi;
    logic [7:0] ptx, prx;
    int n_rise, period, n_mismatch, n_checks, cyc;
    assign sck = sck_oe ? sck_o : sck_drv;
    cssp_top #(.MAX_TAP(TAP)) u_cssp_top (.SYS_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .SHIFT_CLOCK_PIN_I(sck),
        .SHIFT_CLOCK_PIN_O(sck_o), .SHIFT_CLOCK_PIN_OE_O(sck_oe), .SERIAL_IN_PIN_I(si),
        .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE_O(so_oe));
    cssp_peer u_cssp_peer (.sck(sck), .so(so), .arm(arm), .ext_go(ext_go), .tx(ptx), .si(si),
        .sck_drv(sck_drv), .n_rise(n_rise), .period(period), .rx(prx));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [3:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [3:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    function automatic int per_ns(input logic [2:0] src, input logic pd);
        if (src == cssp_pkg::SRC_EXT) return 500;
        if (src == cssp_pkg::SRC_SYSCLK) return 80;
        return (TAP >> (2 * src)) * (pd ? 4 : 2) * 40;
    endfunction
    task automatic start(input logic [7:0] din);
        wr_reg(cssp_pkg::ADR_IRQ_CLEAR, 4'h1);
        ptx <= din;
        arm <= 1'b1;
        wr_reg(cssp_pkg::ADR_START, 4'h1);
        arm <= 1'b0;
    endtask
    task automatic setup(input logic [1:0] pm, input logic [3:0] mb, input logic [3:0] ma);
        wr_reg(cssp_pkg::ADR_PORT_PIN_MODE_A, {2'h0, pm});
        wr_reg(cssp_pkg::ADR_SERIAL_MODE_B, mb);
        wr_reg(cssp_pkg::ADR_SERIAL_MODE_A, ma);
    endtask
    task automatic xfer(input logic [2:0] src, input logic pd, input logic [1:0] pm, input logic [7:0] d,
                        input logic [7:0] din, input logic [7:0] dexp, input logic cd);
        int i;
        setup(pm, {3'h0, pd}, {1'b1, src});
        wr_reg(cssp_pkg::ADR_SERIAL_DATA_LOW, d[3:0]);
        wr_reg(cssp_pkg::ADR_SERIAL_DATA_HIGH, d[7:4]);
        start(din);
        if (src == cssp_pkg::SRC_EXT) ext_go <= 1'b1;
        for (i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
        ext_go <= 1'b0;
        repeat (20) @(posedge clk);
        chk(irq, 1'b1);
        chk(16'(n_rise), 16'h8);
        chk(16'(period), 16'(per_ns(src, pd)));
        chk(so_oe, pm[0]);
        chk(sck_oe, src != cssp_pkg::SRC_EXT);
        if (pm[0] && cd) chk(prx, d);
        @(posedge clk);
        addr <= cssp_pkg::ADR_SERIAL_DATA_LOW;
        rd <= 1'b1;
        @(posedge clk);
        addr <= cssp_pkg::ADR_SERIAL_DATA_HIGH;
        #1 lo = rdata;
        @(posedge clk);
        rd <= 1'b0;
        #1 hi = rdata;
        if (cd) chk({hi, lo}, dexp);
        rd_chk(cssp_pkg::ADR_COUNTER, 4'h0);
        $display("Test transfer source %0d mode %0d done", src, pm);
    endtask
    task automatic t_regs;
        logic [5:0] a[6];
        a = '{cssp_pkg::ADR_PORT_PIN_MODE_A, cssp_pkg::ADR_MISC_CONTROL, cssp_pkg::ADR_SERIAL_MODE_B,
              cssp_pkg::ADR_IRQ_STATUS, cssp_pkg::ADR_IRQ_ENABLE, cssp_pkg::ADR_SERIAL_MODE_A};
        foreach (a[i]) rd_chk(a[i], cssp_pkg::REG_RESET);
        chk({sck_oe, so_oe, irq}, 3'h0);
        wr_reg(cssp_pkg::ADR_MISC_CONTROL, 4'hA);
        rd_chk(cssp_pkg::ADR_MISC_CONTROL, 4'hA);
        wr_reg(6'h3F, 4'h5);
        rd_chk(6'h3F, 4'h0);
        wr_reg(cssp_pkg::ADR_IRQ_ENABLE, 4'h1);
        wr_reg(cssp_pkg::ADR_SERIAL_MODE_B, 4'h2);
        repeat (2) @(posedge clk);
        chk(so, 1'b1);
        wr_reg(cssp_pkg::ADR_SERIAL_MODE_B, 4'h0);
        repeat (2) @(posedge clk);
        chk(so, 1'b0);
        $display("Test registers done");
    endtask
    task automatic t_irq;
        wr_reg(cssp_pkg::ADR_IRQ_ENABLE, 4'h0);
        chk(irq, 1'b0);
        rd_chk(cssp_pkg::ADR_IRQ_STATUS, 4'h1);
        wr_reg(cssp_pkg::ADR_IRQ_ENABLE, 4'h1);
        chk(irq, 1'b1);
        wr_reg(cssp_pkg::ADR_IRQ_CLEAR, 4'h1);
        chk(irq, 1'b0);
        rd_chk(cssp_pkg::ADR_IRQ_STATUS, 4'h0);
        $display("Test interrupt done");
    endtask
    task automatic t_abort;
        int v;
        setup(2'h3, 4'h1, 4'h8);
        start(8'h33);
        repeat (300) @(posedge clk);
        rd_chk(cssp_pkg::ADR_COUNTER, 4'hA);
        wr_reg(cssp_pkg::ADR_SERIAL_MODE_A, 4'h8);
        repeat (3) @(posedge clk);
        rd_chk(cssp_pkg::ADR_IRQ_STATUS, 4'h1);
        rd_chk(cssp_pkg::ADR_COUNTER, 4'h0);
        v = n_rise;
        repeat (400) @(posedge clk);
        chk(16'(n_rise), 16'(v));
        $display("Test abort done");
    endtask
    task automatic t_cont;
        int v;
        setup(2'h0, 4'h0, 4'hA);
        start(8'h00);
        repeat (100) @(posedge clk);
        chk(n_rise > 8, 1'b1);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        v = n_rise;
        repeat (20) @(posedge clk);
        chk(16'(n_rise), 16'(v));
        ce <= 1'b1;
        wr_reg(cssp_pkg::ADR_SERIAL_MODE_A, 4'hA);
        repeat (3) @(posedge clk);
        v = n_rise;
        repeat (50) @(posedge clk);
        chk(16'(n_rise), 16'(v));
        $display("Test continuous clock done");
    endtask
    task automatic report_and_stop;
        $display("Checks made: %0d, mismatches: %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("ERROR at %0t: timeout", $time);
            report_and_stop();
        end
    end
    initial begin
        {rst_b, wr, rd, arm, ext_go, addr, wdata, ptx} = '0;
        ce = 1'b1;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        xfer(3'h1, 1'b0, 2'h3, 8'hA5, 8'h3C, 8'h3C, 1'b1);
        xfer(3'h1, 1'b1, 2'h1, 8'h96, 8'h5A, 8'h00, 1'b1);
        xfer(3'h0, 1'b0, 2'h2, 8'h00, 8'hC3, 8'hC3, 1'b1);
        xfer(3'h2, 1'b1, 2'h3, 8'h69, 8'h81, 8'h81, 1'b1);
        xfer(3'h6, 1'b0, 2'h3, 8'hFF, 8'h00, 8'h00, 1'b0);
        xfer(3'h7, 1'b0, 2'h3, 8'h5A, 8'hE7, 8'hE7, 1'b1);
        t_irq();
        t_abort();
        t_cont();
        report_and_stop();
    end
endmodule
`default_nettype wire
